// file: include/wdt_defines.vh
// constants for the watchdog / interval timer: addresses, keys, fields,
// reset values, prescaler divisors and pulse lengths.
// assumes the includer runs on the peripheral clock (25 MHz here).
//
// How it works
// - eight-bit up-counter, readable and writable, steps once per prescaler tick
// - enable bit starts counting; clearing it stops and zeroes the counter
// - three-bit select picks divide by 2,64,128,512,2048,8192,32768,131072
// - mode bit zero is interval mode, one is watchdog mode
// - interval wrap FF to 00 sets overflow flag and raises interval interrupt
// - interval flag clears by writing 0 after reading it as 1
// - watchdog internal reset clears the interval overflow flag
// - watchdog wrap sets watchdog flag; interval mode never sets it
// - watchdog flag clears by writing 0 after reading it set
// - overflow output low 133 cycles with reset enable, else 130
// - with reset enable, internal reset pulse of 519 cycles starts together
// - without reset enable, no chip reset, but counter and control reset
// - external reset wins over watchdog reset and leaves watchdog flag clear
// - reset control register resets to 1F externally, kept over internal reset
// - internal reset returns system clock control to its initial value
// - fixed-one reserved bits ignore writes; bit 5 of reset control is storage
// - counter write beats a coincident increment
// - writes ignored while the overflow output is low
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH

`define WDT_ADDR_CSR     16'hffa4
`define WDT_ADDR_CNT     16'hffa5
`define WDT_ADDR_RST_WR  16'hffa6
`define WDT_ADDR_RST_RD  16'hffa7

`define WDT_KEY_CNT      8'h5a
`define WDT_KEY_CSR      8'ha5
`define WDT_KEY_RESET_ENABLE_BIT     8'h5a
`define WDT_KEY_WCLR     8'ha5

`define WDT_CSR_OVF      7
`define WDT_CSR_MODE     6
`define WDT_CSR_TME      5
`define WDT_RST_WATCHDOG_OVERFLOW_FLAG     7
`define WDT_RST_RESET_ENABLE_BIT     6
`define WDT_RST_SPARE    5

`define WDT_CSR_FIXED    2'h3
`define WDT_RST_FIXED    5'h1f
`define WDT_CNT_MAX      8'hff

`define WDT_DIV0         18'd2
`define WDT_DIV1         18'd64
`define WDT_DIV2         18'd128
`define WDT_DIV3         18'd512
`define WDT_DIV4         18'd2048
`define WDT_DIV5         18'd8192
`define WDT_DIV6         18'd32768
`define WDT_DIV7         18'd131072

`define WDT_OVF_CYC_RESET_ENABLE_BIT 8'd133
`define WDT_OVF_CYC_NORS 8'd130
`define WDT_IRST_CYC     10'd519

`endif

// file: src/wdt_prescaler.v
// prescaler for the watchdog counter: one-cycle tick every selected divisor.
// assumes i_run low holds the divider at zero, so each start gives a full
// first period.
`timescale 1ns/1ps
`include "wdt_defines.vh"

module wdt_prescaler (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_ce,
  input  wire        i_run,
  input  wire [2:0]  i_sel,
  output wire        o_tick
);

  reg  [16:0] div_q;
  wire [16:0] mask;

  // divisor minus one, all divisors are powers of two
  // the largest divisor needs an 18th bit; the mask itself fits in 17
  function [16:0] div_mask;
    input [2:0] sel;
    reg   [17:0] full;
    begin
      case (sel)
        3'h0:    full = `WDT_DIV0 - 18'd1;
        3'h1:    full = `WDT_DIV1 - 18'd1;
        3'h2:    full = `WDT_DIV2 - 18'd1;
        3'h3:    full = `WDT_DIV3 - 18'd1;
        3'h4:    full = `WDT_DIV4 - 18'd1;
        3'h5:    full = `WDT_DIV5 - 18'd1;
        3'h6:    full = `WDT_DIV6 - 18'd1;
        default: full = `WDT_DIV7 - 18'd1;
      endcase
      div_mask = full[16:0];
    end
  endfunction

  assign mask   = div_mask(i_sel);
  assign o_tick = i_run & ((div_q & mask) == mask);

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_q <= 17'h00000;
    end else if (i_ce) begin
      if (!i_run) begin
        div_q <= 17'h00000;
      end else begin
        div_q <= div_q + 17'h00001;
      end
    end
  end

endmodule

// file: src/wdt_top.v
// watchdog / interval timer with its three protected byte registers.
// assumes a cpu bus that presents one access per cycle, synchronous to
// I_CLK, with I_WORD high for word writes; read data follows one cycle later.
`timescale 1ns/1ps
`include "wdt_defines.vh"

module wdt_top (
  input  wire        I_CLK,
  input  wire        I_SYS_RST,
  input  wire        I_CE,
  input  wire [15:0] I_ADDR,
  input  wire [15:0] I_WDATA,
  input  wire        I_WR,
  input  wire        I_WORD,
  input  wire        I_RD,
  output reg  [7:0]  O_RDATA,
  output reg         O_OVF_N,
  output reg         O_INT_RST,
  output reg         O_IRQ
);

  // counter and control/status
  reg  [7:0] count_q;
  reg  [7:0] count_d;
  reg        ovf_q;
  reg        ovf_d;
  reg        mode_q;
  reg        mode_d;
  reg        tme_q;
  reg        tme_d;
  reg  [2:0] cks_q;
  reg  [2:0] cks_d;
  reg        ovf_armed_q;
  reg        ovf_armed_d;

  // reset control/status
  reg        watchdog_overflow_flag_q;
  reg        watchdog_overflow_flag_d;
  reg        reset_enable_bit_q;
  reg        reset_enable_bit_d;
  reg        spare_q;
  reg        spare_d;
  reg        watchdog_overflow_flag_armed_q;
  reg        watchdog_overflow_flag_armed_d;

  // pulse timers
  reg  [7:0] ovf_cnt_q;
  reg  [7:0] ovf_cnt_d;
  reg  [9:0] irst_cnt_q;
  reg  [9:0] irst_cnt_d;

  reg  [7:0] rdata_d;

  wire       tick;
  wire [7:0] key;
  wire [7:0] wbyte;
  wire       wr_ok;
  wire       wr_cnt;
  wire       wr_csr;
  wire       wr_reset_enable_bit;
  wire       wr_wclr;
  wire       wrap;
  wire       wd_ovf;
  wire       it_ovf;
  wire       clr_ovf;
  wire       clr_watchdog_overflow_flag;
  wire       rd_csr;
  wire       rd_rst;
  wire [7:0] csr_view;
  wire [7:0] rst_view;

  wdt_prescaler u_presc (
    .i_clk  (I_CLK),
    .i_rst  (I_SYS_RST),
    .i_ce   (I_CE),
    .i_run  (tme_q),
    .i_sel  (cks_q),
    .o_tick (tick)
  );

  assign key   = I_WDATA[15:8];
  assign wbyte = I_WDATA[7:0];

  // keyed word writes only; nothing lands while the overflow pulse is out
  assign wr_ok   = I_WR & I_WORD & O_OVF_N;
  assign wr_cnt  = wr_ok & (I_ADDR == `WDT_ADDR_CSR) &
                   (key == `WDT_KEY_CNT);
  assign wr_csr  = wr_ok & (I_ADDR == `WDT_ADDR_CSR) &
                   (key == `WDT_KEY_CSR);
  assign wr_reset_enable_bit = wr_ok & (I_ADDR == `WDT_ADDR_RST_WR) &
                   (key == `WDT_KEY_RESET_ENABLE_BIT);
  assign wr_wclr = wr_ok & (I_ADDR == `WDT_ADDR_RST_WR) &
                   (key == `WDT_KEY_WCLR);

  // wrap FF to 00; a coincident counter write swallows the step
  assign wrap   = tme_q & tick & (count_q == `WDT_CNT_MAX) & ~wr_cnt;
  assign wd_ovf = wrap & mode_q;
  assign it_ovf = wrap & ~mode_q;

  // flag clears need a prior read that saw the flag set
  assign clr_ovf  = wr_csr & ~wbyte[`WDT_CSR_OVF] & ovf_armed_q;
  assign clr_watchdog_overflow_flag = wr_wclr & ~wbyte[`WDT_RST_WATCHDOG_OVERFLOW_FLAG] & watchdog_overflow_flag_armed_q;

  assign rd_csr = I_RD & (I_ADDR == `WDT_ADDR_CSR);
  // a read of the watchdog flag does not count while the pulse is out
  assign rd_rst = I_RD & (I_ADDR == `WDT_ADDR_RST_RD) & O_OVF_N;

  assign csr_view = {ovf_q, mode_q, tme_q, `WDT_CSR_FIXED, cks_q};
  assign rst_view = {watchdog_overflow_flag_q, reset_enable_bit_q, spare_q, `WDT_RST_FIXED};

  // counter
  always @* begin
    count_d = count_q;
    if (wr_cnt) begin
      count_d = wbyte;
    end else if (wd_ovf) begin
      count_d = 8'h00;
    end else if (!tme_q) begin
      count_d = 8'h00;
    end else if (tick) begin
      count_d = count_q + 8'h01;
    end
  end

  // control/status
  always @* begin
    mode_d      = mode_q;
    tme_d       = tme_q;
    cks_d       = cks_q;
    ovf_armed_d = ovf_armed_q;
    if (wr_csr) begin
      mode_d = wbyte[`WDT_CSR_MODE];
      tme_d  = wbyte[`WDT_CSR_TME];
      cks_d  = wbyte[2:0];
    end
    // set wins over a clear in the same cycle
    ovf_d = it_ovf | (ovf_q & ~clr_ovf);
    if (rd_csr && ovf_q) begin
      ovf_armed_d = 1'b1;
    end else if (clr_ovf || !ovf_q) begin
      ovf_armed_d = 1'b0;
    end
    if (wd_ovf) begin
      // own reset of counter and control on every watchdog overflow
      mode_d      = 1'b0;
      tme_d       = 1'b0;
      cks_d       = 3'h0;
      ovf_d       = 1'b0;
      ovf_armed_d = 1'b0;
    end
  end

  // reset control/status, untouched by the internal reset
  always @* begin
    reset_enable_bit_d       = reset_enable_bit_q;
    spare_d      = spare_q;
    watchdog_overflow_flag_armed_d = watchdog_overflow_flag_armed_q;
    if (wr_reset_enable_bit) begin
      reset_enable_bit_d  = wbyte[`WDT_RST_RESET_ENABLE_BIT];
      spare_d = wbyte[`WDT_RST_SPARE];
    end
    watchdog_overflow_flag_d = wd_ovf | (watchdog_overflow_flag_q & ~clr_watchdog_overflow_flag);
    if (rd_rst && watchdog_overflow_flag_q) begin
      watchdog_overflow_flag_armed_d = 1'b1;
    end else if (clr_watchdog_overflow_flag || !watchdog_overflow_flag_q) begin
      watchdog_overflow_flag_armed_d = 1'b0;
    end
  end

  // overflow output and internal reset pulse lengths
  always @* begin
    ovf_cnt_d  = ovf_cnt_q;
    irst_cnt_d = irst_cnt_q;
    if (ovf_cnt_q != 8'h00) begin
      ovf_cnt_d = ovf_cnt_q - 8'h01;
    end
    if (irst_cnt_q != 10'h000) begin
      irst_cnt_d = irst_cnt_q - 10'h001;
    end
    if (wd_ovf) begin
      if (reset_enable_bit_q) begin
        ovf_cnt_d  = `WDT_OVF_CYC_RESET_ENABLE_BIT;
        irst_cnt_d = `WDT_IRST_CYC;
      end else begin
        ovf_cnt_d  = `WDT_OVF_CYC_NORS;
      end
    end
  end

  // registered read data; unmapped reads give zero
  always @* begin
    rdata_d = O_RDATA;
    if (I_RD) begin
      case (I_ADDR)
        `WDT_ADDR_CSR:    rdata_d = csr_view;
        `WDT_ADDR_CNT:    rdata_d = count_q;
        `WDT_ADDR_RST_RD: rdata_d = rst_view;
        default:          rdata_d = 8'h00;
      endcase
    end
  end

  // external reset clears everything, so it also wins over a watchdog hit
  always @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      count_q      <= 8'h00;
      ovf_q        <= 1'b0;
      mode_q       <= 1'b0;
      tme_q        <= 1'b0;
      cks_q        <= 3'h0;
      ovf_armed_q  <= 1'b0;
      watchdog_overflow_flag_q       <= 1'b0;
      reset_enable_bit_q       <= 1'b0;
      spare_q      <= 1'b0;
      watchdog_overflow_flag_armed_q <= 1'b0;
      ovf_cnt_q    <= 8'h00;
      irst_cnt_q   <= 10'h000;
      O_RDATA      <= 8'h00;
      O_OVF_N      <= 1'b1;
      O_INT_RST    <= 1'b0;
      O_IRQ        <= 1'b0;
    end else if (I_CE) begin
      count_q      <= count_d;
      ovf_q        <= ovf_d;
      mode_q       <= mode_d;
      tme_q        <= tme_d;
      cks_q        <= cks_d;
      ovf_armed_q  <= ovf_armed_d;
      watchdog_overflow_flag_q       <= watchdog_overflow_flag_d;
      reset_enable_bit_q       <= reset_enable_bit_d;
      spare_q      <= spare_d;
      watchdog_overflow_flag_armed_q <= watchdog_overflow_flag_armed_d;
      ovf_cnt_q    <= ovf_cnt_d;
      irst_cnt_q   <= irst_cnt_d;
      O_RDATA      <= rdata_d;
      // outputs follow the next counts so both pulses start together
      O_OVF_N      <= (ovf_cnt_d == 8'h00);
      O_INT_RST    <= (irst_cnt_d != 10'h000);
      // interrupt stands while the flag is set, no transfer trigger
      O_IRQ        <= ovf_d;
    end
  end

endmodule

// file: verification/tb_top.sv
// bench for wdt_top: registers, interval, divisors, watchdog overflow.
// assumes I_CE held high; the model owns clock control.
`timescale 1ns/1ps
module tb_top;
  reg        clk = 1'b0;
  reg        rst = 1'b1;
  reg [15:0] addr = 16'h0;
  reg [15:0] wdata = 16'h0;
  reg        wr = 1'b0;
  reg        word = 1'b0;
  reg        rd = 1'b0;
  reg        mwr = 1'b0;
  wire [7:0] rdata;
  wire       ovf_n;
  wire       int_rst;
  wire       irq;
  wire [7:0] clk_ctrl;
  integer    miscompares = 0;
  integer    samples_checked = 0;
  integer    n;
  integer    k;
  integer    d;
  always #20 clk = ~clk;
  wdt_top u_wdt_top (.I_CLK(clk), .I_SYS_RST(rst), .I_CE(1'b1),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_WORD(word), .I_RD(rd),
    .O_RDATA(rdata), .O_OVF_N(ovf_n), .O_INT_RST(int_rst), .O_IRQ(irq));
  wdt_sys_model u_wdt_sys_model (.i_clk(clk), .i_rst(rst),
    .i_int_rst(int_rst), .i_wr(mwr), .i_wdata(8'h07), .o_clk_ctrl(clk_ctrl));
  task end_sim; begin
    $display("compared %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end endtask
  task chk(input [63:0] nm, input [9:0] e, input [9:0] g); begin
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("[FAIL] %0s exp %h got %h", nm, e, g);
    end
  end endtask
  task tick; begin
    @(posedge clk);
    #1;
    k = k + 1;
  end endtask
  task tmo(input integer lim); begin
    if (k >= lim) begin
      chk("wait", 10'h0, 10'h1);
      end_sim;
    end
  end endtask
  task wr16(input [15:0] a, input [15:0] v, input w); begin
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    word <= w;
    @(posedge clk);
    wr <= 1'b0;
  end endtask
  task rdc(input [15:0] a, input [7:0] e); begin
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", {2'b0, e}, {2'b0, rdata});
  end endtask
  task s_regs; begin
    rdc(16'hffa4, 8'h18);
    rdc(16'hffa7, 8'h1f);
    wr16(16'hffa6, 16'h5a3f, 1'b1);
    rdc(16'hffa7, 8'h3f);
    wr16(16'hffa4, 16'h5a55, 1'b0);
    rdc(16'hffa5, 8'h00);
    wr16(16'hffa4, 16'ha500, 1'b1);
    rdc(16'hffa4, 8'h18);
  end endtask
  task s_ivl; begin
    wr16(16'hffa4, 16'ha520, 1'b1);
    wr16(16'hffa4, 16'h5afd, 1'b1);
    k = 0;
    while (irq !== 1'b1 && k < 40) tick;
    tmo(40);
    wr16(16'hffa4, 16'ha5a0, 1'b1);
    wr16(16'hffa4, 16'ha520, 1'b1);
    #1;
    chk("irq", 10'h1, {9'h0, irq});
    rdc(16'hffa4, 8'hb8);
    wr16(16'hffa4, 16'ha500, 1'b1);
    @(posedge clk);
    #1;
    chk("irq", 10'h0, {9'h0, irq});
    rdc(16'hffa5, 8'h00);
  end endtask
  task s_div; begin
    for (n = 0; n < 6; n = n + 1) begin
      d = (n == 0) ? 2 : (n == 1) ? 64 : 1 << (2 * n + 3);
      wr16(16'hffa4, {13'h14a4, n[2:0]}, 1'b1);
      wr16(16'hffa4, 16'h5aff, 1'b1);
      k = 0;
      while (irq !== 1'b1 && k < 9000) tick;
      tmo(9000);
      chk("div_ok", 10'h1, {9'h0, k + 3 >= d && k <= d + 2});
      rdc(16'hffa4, {5'h17, n[2:0]});
      wr16(16'hffa4, 16'ha500, 1'b1);
    end
  end endtask
  task s_wdg(input r); begin
    @(posedge clk);
    mwr <= 1'b1;
    @(posedge clk);
    mwr <= 1'b0;
    wr16(16'hffa6, {9'h0b4, r, 6'h0}, 1'b1);
    wr16(16'hffa4, 16'ha560, 1'b1);
    wr16(16'hffa4, 16'h5afe, 1'b1);
    k = 0;
    while (ovf_n !== 1'b0 && k < 40) tick;
    tmo(40);
    chk("int_rst", {9'h0, r}, {9'h0, int_rst});
    wr16(16'hffa4, 16'h5a40, 1'b1);
    rdc(16'hffa5, 8'h00);
    rdc(16'hffa4, 8'h18);
    k = 0;
    while ((ovf_n !== 1'b1 || int_rst !== 1'b0) && k < 600) tick;
    tmo(600);
    chk("clk_ctrl", r ? 10'h1 : 10'h7, {2'b0, clk_ctrl});
    wr16(16'hffa6, 16'ha500, 1'b1);
    rdc(16'hffa7, {1'b1, r, 6'h1f});
    wr16(16'hffa6, 16'ha500, 1'b1);
    rdc(16'hffa7, {1'b0, r, 6'h1f});
  end endtask
  task s_ext; begin
    wr16(16'hffa6, 16'h5a40, 1'b1);
    wr16(16'hffa4, 16'ha560, 1'b1);
    wr16(16'hffa4, 16'h5aff, 1'b1);
    k = 0;
    while (ovf_n !== 1'b0 && k < 20) tick;
    tmo(20);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc(16'hffa7, 8'h1f);
  end endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    s_regs;
    s_ivl;
    s_div;
    s_wdg(1'b1);
    s_wdg(1'b0);
    s_ext;
    end_sim;
  end
endmodule
bind wdt_top wdt_props u_wdt_props (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
  .I_CE(I_CE), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
  .I_WORD(I_WORD), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_OVF_N(O_OVF_N),
  .O_INT_RST(O_INT_RST), .O_IRQ(O_IRQ));

// file: verification/wdt_sys_model.sv
// far side: owner of system clock control, reset by the internal reset.
// assumes the internal reset request is a synchronous high level.
`timescale 1ns/1ps
module wdt_sys_model #(
  parameter [7:0] CLK_CTRL_INIT = 8'h01
) (
  input  wire       i_clk,
  input  wire       i_rst,
  input  wire       i_int_rst,
  input  wire       i_wr,
  input  wire [7:0] i_wdata,
  output reg  [7:0] o_clk_ctrl
);
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_clk_ctrl <= CLK_CTRL_INIT;
    end else if (i_int_rst) begin
      o_clk_ctrl <= CLK_CTRL_INIT;
    end else if (i_wr) begin
      o_clk_ctrl <= i_wdata;
    end
  end
endmodule

// file: verification/wdt_top_properties.sv
// checker for wdt_top: pulse lengths, fixed bits, read and flag holds.
// assumes it is bound to wdt_top and I_CE stays high.
`timescale 1ns/1ps
module wdt_props (
  input wire        I_CLK,
  input wire        I_SYS_RST,
  input wire        I_CE,
  input wire [15:0] I_ADDR,
  input wire [15:0] I_WDATA,
  input wire        I_WR,
  input wire        I_WORD,
  input wire        I_RD,
  input wire [7:0]  O_RDATA,
  input wire        O_OVF_N,
  input wire        O_INT_RST,
  input wire        O_IRQ
);
  reg [9:0] lo_q;
  reg [9:0] ir_q;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  // run lengths go in counters, far too long for a repetition
  always @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      lo_q <= 10'h0;
      ir_q <= 10'h0;
    end else begin
      lo_q <= O_OVF_N ? 10'h0 : lo_q + 10'h1;
      ir_q <= O_INT_RST ? ir_q + 10'h1 : 10'h0;
    end
  end
  sequence s_rd_rst;
    I_RD && I_ADDR == 16'hffa7;
  endsequence
  a_ovf_len_reset_enable_bit: assert property ($rose(O_OVF_N) && O_INT_RST
    |-> lo_q == 10'd133) else $error("overflow low not 133");
  a_ovf_len_nors: assert property ($rose(O_OVF_N) && !O_INT_RST
    |-> lo_q == 10'd130) else $error("overflow low not 130");
  a_int_rst_len: assert property ($fell(O_INT_RST)
    |-> ir_q == 10'd519) else $error("internal reset not 519");
  a_rst_start: assert property ($rose(O_INT_RST)
    |-> $fell(O_OVF_N)) else $error("reset and overflow apart");
  a_rst_fixed: assert property (s_rd_rst
    |=> O_RDATA[4:0] == 5'h1f) else $error("fixed ones lost");
  a_rdata_hold: assert property (!I_RD
    |=> $stable(O_RDATA)) else $error("read data moved");
  a_wr_locked: assert property (!O_OVF_N && I_RD && I_ADDR == 16'hffa5
    |=> O_RDATA == 8'h00) else $error("counter written while low");
  a_irq_hold: assert property (O_IRQ && !I_WR
    |=> O_IRQ || !O_OVF_N) else $error("flag cleared unasked");
endmodule
